// ---- inc/idcw_pkg.sv ----
// package: word indices, field positions and fixed values of the capability words
package idcw_pkg;
    localparam logic [7:0] W_STANDBY = 8'h32;
    localparam logic [7:0] W_PIO_LEGACY = 8'h33;
    localparam logic [7:0] W_VALIDITY = 8'h35;
    localparam logic [7:0] W_CYLINDERS = 8'h36;
    localparam logic [7:0] W_HEADS = 8'h37;
    localparam logic [7:0] W_SECTORS = 8'h38;
    localparam logic [7:0] W_CAP_LO = 8'h39;
    localparam logic [7:0] W_CAP_HI = 8'h3A;
    localparam logic [7:0] W_MULTI = 8'h3B;
    localparam logic [7:0] W_LBA_LO = 8'h3C;
    localparam logic [7:0] W_LBA_HI = 8'h3D;
    localparam logic [7:0] W_MDMA = 8'h3F;
    localparam logic [7:0] W_ADV_PIO = 8'h40;
    localparam logic [7:0] W_MIN_DMA = 8'h41;
    localparam logic [7:0] W_REC_DMA = 8'h42;
    localparam logic [7:0] W_PIO_NOFLOW = 8'h43;
    localparam logic [7:0] W_PIO_FLOW = 8'h44;
    localparam logic [7:0] W_CARD_SPEC = 8'h45;
    localparam logic [7:0] W_QUEUE = 8'h4B;
    localparam logic [7:0] W_SER_CAP = 8'h4C;
    localparam logic [7:0] W_FEAT_SUP = 8'h4E;
    localparam logic [7:0] W_FEAT_EN = 8'h4F;
    localparam logic [7:0] W_FIRST = 8'h32;
    localparam logic [7:0] W_LAST = 8'h4F;
    localparam logic [7:0] PIO_LEGACY_HI = 8'h02;
    localparam int MULTI_VALID_BIT = 8;
    localparam int CARD_SPEC_BIT = 15;
    localparam int VAL_GEOM_BIT = 0;
    localparam int VAL_TIMING_BIT = 1;
    localparam int VAL_UDMA_BIT = 2;
    localparam int FEAT_LSB = 1;
    localparam int FEAT_MSB = 6;
    localparam logic [5:0] FEAT_EN_RESET = 6'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam int GEOM_LATENCY = 1;
endpackage : idcw_pkg

// ---- rtl/idcw_geom_mult.sv ----
`timescale 1ns/100ps
// module: registered product of cylinders, heads and sectors per track
module idcw_geom_mult
    import idcw_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // geometry in
    input wire logic [15:0] cylinders,
    input wire logic [15:0] heads,
    input wire logic [15:0] sectors,
    // product out
    output logic [31:0] capacity
);
    logic [47:0] full_product;

    assign full_product = cylinders * heads * sectors;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capacity <= 32'h0000_0000;
        end else begin
            capacity <= full_product[31:0];
        end
    end
endmodule : idcw_geom_mult

// ---- rtl/idcw_words.sv ----
`timescale 1ns/100ps
// module: capability words 50 to 79 of the identify data, read by word index
// Notes on behaviour
// - word 50 bit 0 reads one: vendor standby timer minimum applies.
// - word 51 gives highest legacy PIO mode 0..2, upper byte 02h.
// - word 53 bit 0 marks words 54-58 valid, bit 1 words 64-70.
// - word 53 bit 2 reads one: word 88 valid.
// - words 54-56 current geometry, words 57-58 their product.
// - word 59: bits 15-9 zero, bit 8 one, low byte zero or one.
// - words 60-61 give total sectors addressable by LBA.
// - word 63 high byte: one selected multiword DMA mode, bits 8-10.
// - word 63 low byte: supported multiword DMA modes, bits 0-2.
// - word 64 bit 1 PIO mode 4, bit 0 PIO mode 3.
// - word 65 minimum DMA cycle ns, not below fastest mode time.
// - word 66 recommended DMA cycle ns, never below word 65.
// - word 67 PIO cycle without flow control, not below word 68.
// - word 68 PIO cycle with flow control, fastest supported mode.
// - unsupported timing fields in words 64-70 read zero.
// - word 69 bit 15 reads one: card specification supported.
// - word 75 bits 4:0 queue depth minus one, rest zero.
// - word 76 serial capability bits 10,9,8,2,1; bit 0 zero.
// - word 78 supported serial features bits 6-1; others zero.
// - word 79 enabled serial features, same layout as word 78.
// - host may change enables of supported features only; word 79 reflects them.
module idcw_words
    import idcw_pkg::*;
#(
    parameter logic [1:0] LEGACY_PIO_MODE = 2'd2,
    parameter logic [2:0] MDMA_SUPPORT = 3'b111,
    parameter logic [1:0] ADV_PIO_SUPPORT = 2'b11,
    parameter logic [15:0] MIN_DMA_NS = 16'h0078,
    parameter logic [15:0] REC_DMA_NS = 16'h0078,
    parameter logic [15:0] PIO_NOFLOW_NS = 16'h0078,
    parameter logic [15:0] PIO_FLOW_NS = 16'h0078,
    parameter logic [4:0] QUEUE_DEPTH_M1 = 5'h1F,
    parameter logic [4:0] SER_CAP_BITS = 5'b01111,
    parameter logic [5:0] FEAT_SUPPORT = 6'h00
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // device configuration and state
    input wire logic [15:0] CUR_CYLINDERS,
    input wire logic [15:0] CUR_HEADS,
    input wire logic [15:0] CUR_SECTORS,
    input wire logic [31:0] LBA_SECTORS,
    input wire logic MULTI_SECTOR_SET,
    input wire logic [1:0] MDMA_SELECT,
    input wire logic MDMA_SELECTED,
    // host change of serial feature enables
    input wire logic FEAT_EN_WRITE,
    input wire logic [5:0] FEAT_EN_DATA,
    // word read port
    input wire logic READ_REQ,
    input wire logic [7:0] READ_INDEX,
    output logic [15:0] READ_DATA,
    output logic READ_VALID,
    output logic READ_MAPPED
);
    logic [31:0] capacity;
    logic [5:0] feat_en_ff;
    logic [15:0] cyl_ff;
    logic [15:0] heads_ff;
    logic [15:0] sect_ff;
    logic [31:0] lba_ff;
    logic multi_ff;
    logic [2:0] mdma_sel_ff;
    logic [15:0] nxt_data;
    logic nxt_mapped;
    logic timing_any;
    logic [2:0] mdma_usable;
    logic [1:0] legacy_mode;

    // timing field: reads zero when unsupported
    function automatic logic [15:0] timing_word(input logic sup, input logic [15:0] ns);
        timing_word = sup ? ns : WORD_RESET;
    endfunction : timing_word

    // one-hot of a selected mode, none when not selected
    function automatic logic [2:0] one_hot_mode(input logic sel, input logic [1:0] mode);
        logic [2:0] oh;
        oh = 3'b000;
        if (sel && mode <= 2'd2) begin
            oh[mode] = 1'b1;
        end
        one_hot_mode = oh;
    endfunction : one_hot_mode

    idcw_geom_mult u_geom_mult (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .cylinders(cyl_ff),
        .heads(heads_ff),
        .sectors(sect_ff),
        .capacity(capacity)
    );

    // snapshot of device state
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cyl_ff <= WORD_RESET;
            heads_ff <= WORD_RESET;
            sect_ff <= WORD_RESET;
            lba_ff <= 32'h0000_0000;
            multi_ff <= 1'b0;
            mdma_sel_ff <= 3'b000;
        end else begin
            cyl_ff <= CUR_CYLINDERS;
            heads_ff <= CUR_HEADS;
            sect_ff <= CUR_SECTORS;
            lba_ff <= LBA_SECTORS;
            multi_ff <= MULTI_SECTOR_SET;
            mdma_sel_ff <= one_hot_mode(MDMA_SELECTED, MDMA_SELECT) & mdma_usable;
        end
    end

    // serial feature enables, host writable
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            feat_en_ff <= FEAT_EN_RESET;
        end else if (FEAT_EN_WRITE) begin
            feat_en_ff <= FEAT_EN_DATA & FEAT_SUPPORT;
        end
    end

    assign timing_any = (|MDMA_SUPPORT) | (|ADV_PIO_SUPPORT);

    // a support bit covers its own mode and all slower ones
    assign mdma_usable = {MDMA_SUPPORT[2], |MDMA_SUPPORT[2:1], |MDMA_SUPPORT};

    // legacy field never reports above mode 2
    assign legacy_mode = (LEGACY_PIO_MODE > 2'h2) ? 2'h2 : LEGACY_PIO_MODE;

    // word decode
    always_comb begin
        nxt_data = WORD_RESET;
        nxt_mapped = 1'b1;
        if (READ_INDEX == W_STANDBY) begin
            nxt_data[0] = 1'b1;
        end else if (READ_INDEX == W_PIO_LEGACY) begin
            nxt_data = {PIO_LEGACY_HI, 6'h00, legacy_mode};
        end else if (READ_INDEX == W_VALIDITY) begin
            nxt_data[VAL_GEOM_BIT] = 1'b1;
            nxt_data[VAL_TIMING_BIT] = timing_any;
            nxt_data[VAL_UDMA_BIT] = 1'b1;
        end else if (READ_INDEX == W_CYLINDERS) begin
            nxt_data = cyl_ff;
        end else if (READ_INDEX == W_HEADS) begin
            nxt_data = heads_ff;
        end else if (READ_INDEX == W_SECTORS) begin
            nxt_data = sect_ff;
        end else if (READ_INDEX == W_CAP_LO) begin
            nxt_data = capacity[15:0];
        end else if (READ_INDEX == W_CAP_HI) begin
            nxt_data = capacity[31:16];
        end else if (READ_INDEX == W_MULTI) begin
            nxt_data[MULTI_VALID_BIT] = 1'b1;
            nxt_data[0] = multi_ff;
        end else if (READ_INDEX == W_LBA_LO) begin
            nxt_data = lba_ff[15:0];
        end else if (READ_INDEX == W_LBA_HI) begin
            nxt_data = lba_ff[31:16];
        end else if (READ_INDEX == W_MDMA) begin
            nxt_data = {5'h00, mdma_sel_ff, 5'h00, MDMA_SUPPORT};
        end else if (READ_INDEX == W_ADV_PIO) begin
            nxt_data = {14'h0000, ADV_PIO_SUPPORT};
        end else if (READ_INDEX == W_MIN_DMA) begin
            nxt_data = timing_word(|MDMA_SUPPORT[2:1], MIN_DMA_NS);
        end else if (READ_INDEX == W_REC_DMA) begin
            nxt_data = timing_word(|MDMA_SUPPORT[2:1],
                (REC_DMA_NS < MIN_DMA_NS) ? MIN_DMA_NS : REC_DMA_NS);
        end else if (READ_INDEX == W_PIO_NOFLOW) begin
            nxt_data = timing_word(|ADV_PIO_SUPPORT,
                (PIO_NOFLOW_NS < PIO_FLOW_NS) ? PIO_FLOW_NS : PIO_NOFLOW_NS);
        end else if (READ_INDEX == W_PIO_FLOW) begin
            nxt_data = timing_word(|ADV_PIO_SUPPORT, PIO_FLOW_NS);
        end else if (READ_INDEX == W_CARD_SPEC) begin
            nxt_data[CARD_SPEC_BIT] = 1'b1;
        end else if (READ_INDEX == W_QUEUE) begin
            nxt_data = {11'h000, QUEUE_DEPTH_M1};
        end else if (READ_INDEX == W_SER_CAP) begin
            nxt_data = {5'h00, SER_CAP_BITS[4:2], 5'h00, SER_CAP_BITS[1:0], 1'b0};
        end else if (READ_INDEX == W_FEAT_SUP) begin
            nxt_data[FEAT_MSB:FEAT_LSB] = FEAT_SUPPORT;
        end else if (READ_INDEX == W_FEAT_EN) begin
            nxt_data[FEAT_MSB:FEAT_LSB] = feat_en_ff;
        end else begin
            nxt_mapped = (READ_INDEX >= W_FIRST) && (READ_INDEX <= W_LAST);
        end
    end

    // registered read answer
    always_ff @(posedge REF_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            READ_DATA <= WORD_RESET;
            READ_VALID <= 1'b0;
            READ_MAPPED <= 1'b0;
        end else begin
            READ_VALID <= READ_REQ;
            if (READ_REQ) begin
                READ_DATA <= nxt_data;
                READ_MAPPED <= nxt_mapped;
            end
        end
    end
endmodule : idcw_words

// ---- testbench/idcw_words_monitor.sv ----
// checker: read port properties of the capability words
`timescale 1ns/100ps
module idcw_words_monitor
    import idcw_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // read port
    input wire logic READ_REQ,
    input wire logic [7:0] READ_INDEX,
    input wire logic [15:0] READ_DATA,
    input wire logic READ_VALID,
    input wire logic READ_MAPPED
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    chk_standby_word: assert property (
        READ_REQ && READ_INDEX == W_STANDBY |=> READ_DATA == 16'h0001) else $error("word 50");
    chk_legacy_pio: assert property (
        READ_REQ && READ_INDEX == W_PIO_LEGACY |=> READ_DATA[15:8] == PIO_LEGACY_HI
        && READ_DATA[7:0] <= 8'h02) else $error("word 51");
    chk_validity_word: assert property (
        READ_REQ && READ_INDEX == W_VALIDITY |=> READ_DATA[2] && READ_DATA[0]
        && READ_DATA[15:3] == 13'h0000) else $error("word 53");
    chk_multi_setting: assert property (
        READ_REQ && READ_INDEX == W_MULTI |=> READ_DATA[15:1] == 15'h0080) else $error("word 59");
    chk_mdma_word: assert property (
        READ_REQ && READ_INDEX == W_MDMA |=> $onehot0(READ_DATA[15:8])
        && READ_DATA[15:11] == 5'h00 && READ_DATA[7:3] == 5'h00) else $error("word 63");
    chk_card_spec: assert property (
        READ_REQ && READ_INDEX == W_CARD_SPEC |=> READ_DATA == 16'h8000) else $error("word 69");
    chk_queue_depth: assert property (
        READ_REQ && READ_INDEX == W_QUEUE |=> READ_DATA[15:5] == 11'h000) else $error("word 75");
    chk_feature_layout: assert property (
        READ_REQ && (READ_INDEX == W_FEAT_SUP || READ_INDEX == W_FEAT_EN)
        |=> !READ_DATA[0] && READ_DATA[15:7] == 9'h000) else $error("word 78/79");
    chk_unmapped_zero: assert property (
        READ_REQ && (READ_INDEX < W_FIRST || READ_INDEX > W_LAST)
        |=> READ_DATA == 16'h0000 && !READ_MAPPED) else $error("unmapped word");
    chk_answer_timing: assert property (
        READ_VALID == $past(READ_REQ)) else $error("answer not one cycle after request");
    chk_data_hold: assert property (
        !READ_REQ |=> $stable(READ_DATA) && $stable(READ_MAPPED)) else $error("answer not held");
    chk_adv_pio: assert property (
        READ_REQ && READ_INDEX == W_ADV_PIO |=> READ_DATA[15:2] == 14'h0000)
        else $error("word 64");
    chk_serial_caps: assert property (
        READ_REQ && READ_INDEX == W_SER_CAP |=> !READ_DATA[0] && READ_DATA[15:11] == 5'h00
        && READ_DATA[7:3] == 5'h00) else $error("word 76");
    cover property (READ_REQ && READ_INDEX == W_FEAT_EN);
    cover property (READ_REQ && READ_INDEX == W_CAP_HI);
    cover property (READ_REQ && READ_INDEX > W_LAST);
endmodule : idcw_words_monitor
bind idcw_words idcw_words_monitor u_mon (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
    .READ_REQ(READ_REQ), .READ_INDEX(READ_INDEX), .READ_DATA(READ_DATA),
    .READ_VALID(READ_VALID),
    .READ_MAPPED(READ_MAPPED));

// ---- testbench/idcw_host_model.sv ----
// partner: host issuing identify word reads and feature enable writes
`timescale 1ns/100ps
module idcw_host_model (
    // clock
    input wire logic clk,
    // requests
    output logic read_req,
    output logic [7:0] read_index,
    output logic feat_en_write,
    output logic [5:0] feat_en_data,
    // answers
    input wire logic [15:0] read_data,
    input wire logic read_valid,
    input wire logic read_mapped
);
    initial begin
        read_req = 1'b0;
        read_index = 8'hFF;
        feat_en_write = 1'b0;
        feat_en_data = 6'h3F;
    end
    // idle gap first gives slow or back-to-back hosts
    task automatic read_word(input logic [7:0] i, input int gap, output logic [15:0] d,
        output logic m, output logic v);
        repeat (gap) @(posedge clk);
        #1;
        read_req = 1'b1;
        read_index = i;
        @(posedge clk);
        #1;
        read_req = 1'b0;
        read_index = ~i;
        v = read_valid;
        d = read_data;
        m = read_mapped;
    endtask : read_word
    task automatic write_feat(input logic [5:0] en);
        @(posedge clk);
        #1;
        feat_en_write = 1'b1;
        feat_en_data = en;
        @(posedge clk);
        #1;
        feat_en_write = 1'b0;
        feat_en_data = ~en;
    endtask : write_feat
endmodule : idcw_host_model

// ---- testbench/testbench.sv ----
// testbench: capability words read through the host model
`timescale 1ns/100ps
module testbench import idcw_pkg::*;;
    localparam logic [5:0] FS = 6'h2B;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] cyl = 16'h0100, hds = 16'h0010, sec = 16'h003F;
    logic [31:0] lba = 32'h003E_FC00;
    logic multi = 1'b1, msd = 1'b1, req, fw, rv, rm;
    logic [1:0] msel = 2'h2;
    logic [5:0] en_set = 6'h00, fd;
    logic [7:0] idx;
    logic [15:0] rd;
    int errors = 0, samples_checked = 0;
    always #10 clk = ~clk;
    idcw_words #(.REC_DMA_NS(16'h0096), .PIO_NOFLOW_NS(16'h00B4), .SER_CAP_BITS(5'b10111),
        .FEAT_SUPPORT(FS)) u_idcw_words (.REF_CLK(clk), .RESET_N(rst_n), .CUR_CYLINDERS(cyl),
        .CUR_HEADS(hds), .CUR_SECTORS(sec), .LBA_SECTORS(lba), .MULTI_SECTOR_SET(multi),
        .MDMA_SELECT(msel), .MDMA_SELECTED(msd), .FEAT_EN_WRITE(fw), .FEAT_EN_DATA(fd),
        .READ_REQ(req), .READ_INDEX(idx), .READ_DATA(rd), .READ_VALID(rv), .READ_MAPPED(rm));
    idcw_host_model u_idcw_host_model (.clk(clk), .read_req(req), .read_index(idx),
        .feat_en_write(fw), .feat_en_data(fd), .read_data(rd), .read_valid(rv), .read_mapped(rm));
    function automatic logic [15:0] exp_word(input logic [7:0] i);
        logic [31:0] cap;
        cap = {16'h0000, cyl} * {16'h0000, hds} * {16'h0000, sec};
        case (i)
            W_STANDBY: return 16'h0001;
            W_PIO_LEGACY: return 16'h0202;
            W_VALIDITY: return 16'h0007;
            W_CYLINDERS: return cyl;
            W_HEADS: return hds;
            W_SECTORS: return sec;
            W_CAP_LO: return cap[15:0];
            W_CAP_HI: return cap[31:16];
            W_MULTI: return {15'h0080, multi};
            W_LBA_LO: return lba[15:0];
            W_LBA_HI: return lba[31:16];
            W_MDMA: return {5'h00, msd ? 3'(1 << msel) : 3'h0, 8'h07};
            W_ADV_PIO: return 16'h0003;
            W_MIN_DMA, W_PIO_FLOW: return 16'h0078;
            W_REC_DMA: return 16'h0096;
            W_PIO_NOFLOW: return 16'h00B4;
            W_CARD_SPEC: return 16'h8000;
            W_QUEUE: return 16'h001F;
            W_SER_CAP: return 16'h0506;
            W_FEAT_SUP: return {9'h000, FS, 1'b0};
            W_FEAT_EN: return {9'h000, en_set & FS, 1'b0};
            default: return 16'h0000;
        endcase
    endfunction : exp_word
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rd_chk(input logic [7:0] i, input int gap, input logic [15:0] e, input logic m);
        logic [15:0] d;
        logic dm, dv;
        u_idcw_host_model.read_word(i, gap, d, dm, dv);
        check("flags", {14'h0000, dv, dm}, {14'h0000, 1'b1, m});
        check($sformatf("word %h", i), d, e);
    endtask : rd_chk
    task automatic t_sweep(input logic [7:0] lo, input logic [7:0] hi, input int gap);
        for (int i = lo; i <= hi; i++) rd_chk(8'(i), gap, exp_word(8'(i)), 1'b1);
        $display("sweep %h to %h done", lo, hi);
    endtask : t_sweep
    task automatic t_geom;
        @(posedge clk);
        #1;
        cyl = 16'hFFFF;
        hds = 16'h00FF;
        lba = 32'hFFFF_FFFF;
        multi = 1'b0;
        repeat (3) @(posedge clk);
        t_sweep(W_CYLINDERS, W_LBA_HI, 0);
    endtask : t_geom
    task automatic t_mdma;
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            #1;
            msel = 2'(k);
            msd = (k < 4);
            repeat (2) @(posedge clk);
            rd_chk(W_MDMA, 0, exp_word(W_MDMA), 1'b1);
        end
        $display("dma select done");
    endtask : t_mdma
    task automatic t_feat;
        logic [5:0] v[3] = '{6'h3F, 6'h14, 6'h00};
        foreach (v[k]) begin
            u_idcw_host_model.write_feat(v[k]);
            en_set = v[k];
            rd_chk(W_FEAT_EN, 0, exp_word(W_FEAT_EN), 1'b1);
        end
        $display("feature enables done");
    endtask : t_feat
    task automatic t_unmapped;
        logic [7:0] u[4] = '{8'h00, 8'h31, 8'h50, 8'hFF};
        foreach (u[k]) rd_chk(u[k], 1, 16'h0000, 1'b0);
        $display("unmapped done");
    endtask : t_unmapped
    task automatic t_reset;
        u_idcw_host_model.write_feat(6'h3F);
        en_set = 6'h3F;
        rd_chk(W_FEAT_EN, 0, exp_word(W_FEAT_EN), 1'b1);
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("reset data", rd, 16'h0000);
        check("reset flags", {14'h0000, rv, rm}, 16'h0000);
        rst_n = 1'b1;
        en_set = 6'h00;
        repeat (3) @(posedge clk);
        rd_chk(W_FEAT_EN, 0, exp_word(W_FEAT_EN), 1'b1);
        rd_chk(W_CAP_HI, 0, exp_word(W_CAP_HI), 1'b1);
        $display("mid-run reset done");
    endtask : t_reset
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge clk);
        t_sweep(W_FIRST, W_LAST, 0);
        t_sweep(W_FIRST, W_LAST, 3);
        t_geom;
        t_mdma;
        t_feat;
        t_unmapped;
        t_reset;
        results;
    end
    initial begin
        #100us;
        errors++;
        results;
    end
endmodule : testbench
